//--- rtl/program_memory_table_read.v
// Purpose: Table look-up unit reading fixed data from program memory
// Assumes: One instruction cycle per core_clk_i rising edge, memory answers one cycle after request
// Notes: Pointer writes come from the core; latch is read only
// Behaviour
// (R1) A paged read addresses memory with the high pointer above the low pointer.
// (R2) A last-page read uses the low pointer as offset into the page at 0700H.
// (R3) Each table read loads the word's high part into the table-high latch.
// (R4) Software may read the table-high latch but never write it.
// (R5) Each table read takes two instruction cycles from start to completion.
// (R6) Software should mask interrupts around main-routine reads if handlers also read tables.
// (R7) The low byte of the fetched word goes to the data register named by the operand.
// (R8) Latch bits beyond the program word width read as zero.
// (R9) Latch and pointers hold their values until a read or a software write changes them.
`timescale 1ns/100ps
`default_nettype none
`include "table_read_defs.vh"
module program_memory_table_read #(
  parameter ADDR_W = `TRD_ADDR_W,
  parameter WORD_W = `TRD_WORD_W
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire ptr_low_we_i,
  input wire ptr_high_we_i,
  input wire [7:0] ptr_wdata_i,
  input wire table_read_i,
  input wire last_page_table_read_i,
  input wire [7:0] dest_sel_i,
  input wire [WORD_W-1:0] pmem_rdata_i,
  output wire [ADDR_W-1:0] pmem_addr_o,
  output wire pmem_re_o,
  output reg [7:0] ptr_low_o,
  output reg [ADDR_W-9:0] ptr_high_o,
  output reg [7:0] table_high_latch_o,
  output reg [7:0] dest_wdata_o,
  output reg [7:0] dest_addr_o,
  output reg dest_we_o,
  output wire busy_o,
  output reg done_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_FETCH = 1'b1;
  localparam PTR_HIGH_W = ADDR_W - 8;
  reg state_r;
  reg state_nxt;
  reg [7:0] dest_r;
  reg [7:0] dest_nxt;
  reg [7:0] ptr_low_nxt;
  reg [PTR_HIGH_W-1:0] ptr_high_nxt;
  reg [7:0] latch_nxt;
  reg [7:0] dest_wdata_nxt;
  reg [7:0] dest_addr_nxt;
  reg dest_we_nxt;
  reg done_nxt;
  wire start;
  wire fetch_done;
  wire [7:0] low_part;
  wire [7:0] high_part;
  wire [ADDR_W-1:0] addr_int;

  // Requests during a read are ignored; the core stalls for the second cycle
  assign start = (state_r == ST_IDLE) && (table_read_i || last_page_table_read_i);
  assign fetch_done = (state_r == ST_FETCH);
  assign busy_o = fetch_done;
  assign pmem_re_o = start;

  // Last-page strobe wins the address if both strobes are high
  table_addr_gen #(
    .ADDR_W(ADDR_W)
  ) u_addr (
    .ptr_low_i(ptr_low_o),
    .ptr_high_i(ptr_high_o),
    .last_page_i(last_page_table_read_i),
    .addr_o(addr_int)
  );
  assign pmem_addr_o = addr_int;

  assign low_part = pmem_rdata_i[7:0]; // (R7)
  // Zero fill above the word width
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_hi
      if (i + 8 < WORD_W) begin : g_used
        assign high_part[i] = pmem_rdata_i[i+8];
      end else begin : g_zero
        assign high_part[i] = 1'b0; // (R8)
      end
    end
  endgenerate

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_nxt = ST_IDLE; // (R5)
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // A pointer write in the start cycle lands after the address was formed
  always @* begin
    ptr_low_nxt = ptr_low_o;
    ptr_high_nxt = ptr_high_o;
    if (ptr_low_we_i) begin
      ptr_low_nxt = ptr_wdata_i; // (R9)
    end
    if (ptr_high_we_i) begin
      ptr_high_nxt = ptr_wdata_i[PTR_HIGH_W-1:0]; // (R9)
    end
  end

  // Destination number is taken with the strobe, so the core may move on
  always @* begin
    dest_nxt = dest_r;
    if (start) begin
      dest_nxt = dest_sel_i;
    end
  end

  // No write path exists to the latch; only completion loads it
  always @* begin
    latch_nxt = table_high_latch_o; // (R9)
    if (fetch_done) begin
      latch_nxt = high_part; // (R3) (R4)
    end
  end

  always @* begin
    dest_wdata_nxt = dest_wdata_o;
    dest_addr_nxt = dest_addr_o;
    dest_we_nxt = 1'b0;
    done_nxt = 1'b0;
    if (fetch_done) begin
      dest_wdata_nxt = low_part; // (R7)
      dest_addr_nxt = dest_r; // (R7)
      dest_we_nxt = 1'b1;
      done_nxt = 1'b1; // (R5)
    end
  end

  // One register per process keeps each reset value next to its register
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      ptr_low_o <= 8'h00;
    end else begin
      ptr_low_o <= ptr_low_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      ptr_high_o <= {PTR_HIGH_W{1'b0}};
    end else begin
      ptr_high_o <= ptr_high_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      dest_r <= 8'h00;
    end else begin
      dest_r <= dest_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      table_high_latch_o <= `TRD_LATCH_RESET;
    end else begin
      table_high_latch_o <= latch_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      dest_wdata_o <= 8'h00;
    end else begin
      dest_wdata_o <= dest_wdata_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      dest_addr_o <= 8'h00;
    end else begin
      dest_addr_o <= dest_addr_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      dest_we_o <= 1'b0;
    end else begin
      dest_we_o <= dest_we_nxt;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= done_nxt;
    end
  end
endmodule
`default_nettype wire

//--- rtl/table_read_defs.vh
// Purpose: Constants for the program memory table read unit
// Assumes: 2K-word program memory, 16-bit words
// Notes: Included by the table read modules
`ifndef TABLE_READ_DEFS_VH
`define TABLE_READ_DEFS_VH
`define TRD_ADDR_W 11
`define TRD_WORD_W 16
`define TRD_LAST_PAGE_BASE 11'h700
`define TRD_PTR_HIGH_W 3
`define TRD_CYCLES 2'h2
`define TRD_LATCH_RESET 8'h00
`endif

//--- rtl/table_addr_gen.v
// Purpose: Forms the program memory address for a table read
// Assumes: Pointers are stable while a read is in progress
// Notes: Pure combinational address mux
`timescale 1ns/100ps
`default_nettype none
`include "table_read_defs.vh"
module table_addr_gen #(
  parameter ADDR_W = `TRD_ADDR_W,
  parameter [ADDR_W-1:0] LAST_PAGE_BASE = `TRD_LAST_PAGE_BASE
) (
  input wire [7:0] ptr_low_i,
  input wire [ADDR_W-9:0] ptr_high_i,
  input wire last_page_i,
  output wire [ADDR_W-1:0] addr_o
);
  wire [ADDR_W-1:0] paged_addr;
  wire [ADDR_W-1:0] last_addr;
  assign paged_addr = {ptr_high_i, ptr_low_i}; // (R1)
  assign last_addr = {LAST_PAGE_BASE[ADDR_W-1:8], ptr_low_i}; // (R2)
  assign addr_o = last_page_i ? last_addr : paged_addr;
endmodule
`default_nettype wire

//--- verification/pmem_model.sv
// Purpose: Program memory model. Assumes: one-cycle read. Notes: Idle word toggles
`timescale 1ns/100ps
`default_nettype none
module pmem_model (
  input wire logic core_clk_i,
  input wire logic re_i,
  input wire logic [10:0] addr_i,
  output logic [15:0] rdata_o = 16'h0
);
  // Idle word changes each cycle, so a stale word is never mistaken for a fresh one
  always @(posedge core_clk_i)
    rdata_o <= re_i ? {addr_i[7:0] ^ 8'ha5, addr_i[10:3]} : ~rdata_o;
endmodule
`default_nettype wire

//--- verification/program_memory_table_read_assertions.sv
// Purpose: Port-level checks of the table read unit
// Assumes: One read per two cycles, memory answers one cycle after the strobe
// Notes: Sees only the unit's ports; bound after the module
`timescale 1ns/100ps
`default_nettype none
module pmtr_chk (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic table_read_i,
  input wire logic last_page_table_read_i,
  input wire logic ptr_low_we_i,
  input wire logic pmem_re_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic dest_we_o,
  input wire logic [15:0] pmem_rdata_i,
  input wire logic [10:0] pmem_addr_o,
  input wire logic [7:0] ptr_low_o,
  input wire logic [7:0] table_high_latch_o,
  input wire logic [7:0] dest_wdata_o,
  input wire logic [2:0] ptr_high_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire logic go = !busy_o && (table_read_i || last_page_table_read_i);
  property p_pg;
    go && !last_page_table_read_i |-> pmem_addr_o == {ptr_high_o, ptr_low_o};
  endproperty
  a_pg: assert property (p_pg) else $error("paged addr");
  property p_lp; go && last_page_table_read_i |-> pmem_addr_o == {3'h7, ptr_low_o}; endproperty
  a_lp: assert property (p_lp) else $error("last page addr");
  property p_hi; pmem_re_o |-> ##2 table_high_latch_o == $past(pmem_rdata_i[15:8]); endproperty
  a_hi: assert property (p_hi) else $error("latch");
  property p_st; !done_o |-> $stable(table_high_latch_o); endproperty
  a_st: assert property (p_st) else $error("latch moved");
  property p_2c; go |=> busy_o ##1 done_o; endproperty
  a_2c: assert property (p_2c) else $error("cycles");
  property p_rf; busy_o |-> !pmem_re_o; endproperty
  a_rf: assert property (p_rf) else $error("start while busy");
  property p_lo; dest_we_o |-> dest_wdata_o == $past(pmem_rdata_i[7:0]); endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_pl; !ptr_low_we_i |=> $stable(ptr_low_o); endproperty
  a_pl: assert property (p_pl) else $error("pointer moved");
  c_lp: cover property (go && last_page_table_read_i);
  c_bb: cover property (done_o && pmem_re_o);
  c_rf: cover property (busy_o && table_read_i);
endmodule
bind program_memory_table_read pmtr_chk u_chk (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .table_read_i(table_read_i),
  .last_page_table_read_i(last_page_table_read_i),
  .ptr_low_we_i(ptr_low_we_i),
  .pmem_re_o(pmem_re_o),
  .busy_o(busy_o),
  .done_o(done_o),
  .dest_we_o(dest_we_o),
  .pmem_rdata_i(pmem_rdata_i),
  .pmem_addr_o(pmem_addr_o),
  .ptr_low_o(ptr_low_o),
  .table_high_latch_o(table_high_latch_o),
  .dest_wdata_o(dest_wdata_o),
  .ptr_high_o(ptr_high_o)
);
`default_nettype wire

//--- verification/tb_program_memory_table_read.sv
// Purpose: Table read bench. Assumes: model answers next cycle. Notes: Random pointers
`timescale 1ns/100ps
`default_nettype none
module tb_program_memory_table_read;
  logic clk = 0, rst = 1, lw = 0, hw = 0, tr = 0, lp = 0, re, we;
  logic [7:0] wd = 0, ds = 0, pl = 0, th, dw, da;
  logic [2:0] ph = 0;
  logic [15:0] rd;
  logic [10:0] a;
  logic [23:0] q[$];
  int errors = 0, n_checks = 0, i;
  program_memory_table_read uut (.core_clk_i(clk), .srst_i(rst), .ptr_low_we_i(lw),
    .ptr_high_we_i(hw), .ptr_wdata_i(wd), .table_read_i(tr), .last_page_table_read_i(lp),
    .dest_sel_i(ds), .pmem_rdata_i(rd), .pmem_addr_o(a), .pmem_re_o(re), .ptr_low_o(),
    .ptr_high_o(), .table_high_latch_o(th), .dest_wdata_o(dw), .dest_addr_o(da),
    .dest_we_o(we), .busy_o(), .done_o());
  pmem_model pm (.core_clk_i(clk), .re_i(re), .addr_i(a), .rdata_o(rd));
  initial forever #50 clk = ~clk;
  task chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wp;
    @(negedge clk) tr = 0;
    lw = 1;
    wd = 8'($urandom);
    pl = wd;
    @(negedge clk) lw = 0;
    hw = 1;
    wd = 8'($urandom);
    ph = wd[2:0];
    @(negedge clk) hw = 0;
  endtask
  task rdt(input logic l);
    logic [10:0] ad;
    ad = l ? {3'h7, pl} : {ph, pl};
    // One read in flight at a time, as a main routine with interrupts masked issues them
    @(negedge clk) tr = !l;
    lp = l;
    ds = 8'($urandom);
    q.push_back({ds, ad[7:0] ^ 8'ha5, ad[10:3]});
    // A strobe in the busy cycle must be ignored
    @(negedge clk) tr = 1'($urandom);
    lp = 0;
  endtask
  // Results are settled by the falling edge, half a cycle after launch
  always @(negedge clk) begin
    if (we === 1'b1) chk({da, th, dw}, q.size() ? q.pop_front() : 'x);
  end
  initial begin
    i = $urandom(32'hf5c9c2e2);
    repeat (2) @(negedge clk);
    rst = 0;
    for (i = 0; i < 40; i++) begin
      if (i % 4 == 0) wp;
      rdt(1'($urandom));
    end
    @(negedge clk) tr = 0;
    repeat (3) @(negedge clk);
    chk(24'(q.size()), 24'h0);
    $display("random table reads done");
    print_verdict;
  end
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
